// [pkg/fsc_consts.svh]
// Offsets, field positions, masks and reset values of the fault status block
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
// Register addresses (full 32-bit byte addresses)
`define FSC_ADDR_COMBINED 32'hE000ED28
`define FSC_ADDR_HARD 32'hE000ED2C
`define FSC_ADDR_MEM_ADDR 32'hE000ED30
`define FSC_ADDR_BUS_ADDR 32'hE000ED34
// Byte lanes of the combined word
`define FSC_LANE_MEM 0
`define FSC_LANE_BUS 1
`define FSC_LANE_USAGE 2
// Memory-manage status byte
`define FSC_MEM_VALID_BIT 7
`define FSC_MEM_IMPL 8'h80
// Bus-fault status byte
`define FSC_BUS_VALID_BIT 7
`define FSC_BUS_STACK_BIT 5
`define FSC_BUS_UNSTACK_BIT 4
`define FSC_BUS_PRECISE_BIT 1
`define FSC_BUS_IFETCH_BIT 0
`define FSC_BUS_IMPL 8'hB3
// Usage-fault status halfword
`define FSC_USE_DIVZERO_BIT 9
`define FSC_USE_UNALIGN_BIT 8
`define FSC_USE_STKOVF_BIT 4
`define FSC_USE_COPROCESSOR_ABSENT_FLAG_BIT 3
`define FSC_USE_BADPC_BIT 2
`define FSC_USE_BADSTATE_BIT 1
`define FSC_USE_UNDEF_BIT 0
`define FSC_USE_IMPL 16'h031F
// Hard-fault status word
`define FSC_HARD_DEBUG_BIT 31
`define FSC_HARD_FORCED_BIT 30
`define FSC_HARD_VECTOR_BIT 1
`define FSC_HARD_IMPL 32'hC0000002
// Reset values
`define FSC_RESET_STATUS 32'h00000000
`define FSC_RESET_ADDR 32'h00000000
`endif

// [pkg/fsc_pkg.sv]
// Types shared by the fault status block
package fsc_pkg;
  // Access size of a register request
  typedef enum logic [1:0] {
    FSC_SIZE_BYTE = 2'h0,
    FSC_SIZE_HALF = 2'h1,
    FSC_SIZE_WORD = 2'h2
  } fsc_size_t;
  // Register selected by a decoded address
  typedef enum logic [4:0] {
    FSC_REG_NONE = 5'h01,
    FSC_REG_COMBINED = 5'h02,
    FSC_REG_HARD = 5'h04,
    FSC_REG_MEM_ADDR = 5'h08,
    FSC_REG_BUS_ADDR = 5'h10
  } fsc_reg_t;
  typedef logic [3:0] fsc_lanes_t;
endpackage

// [pkg/fsc_if.sv]
// Carriers between the fault status top and its storage modules
`timescale 1ns/1ns
interface fsc_flag_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] value;
  modport owner (input set, input clr, output value);
  modport user (output set, output clr, input value);
endinterface

interface fsc_addr_if;
  logic load;
  logic [31:0] load_val;
  logic sw_we;
  logic [31:0] sw_data;
  logic [31:0] value;
  modport owner (input load, input load_val, input sw_we, input sw_data,
                 output value);
  modport user (output load, output load_val, output sw_we, output sw_data,
                input value);
endinterface

// [verilog/fsc_sticky.sv]
// Write-one-to-clear sticky flag register of configurable width
`timescale 1ns/1ns
module fsc_sticky #(
  parameter int W = 8,
  parameter logic [W-1:0] IMPL = '1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  fsc_flag_if.owner f
);
  logic [W-1:0] q;

  // One flop per implemented bit; a set in the clearing cycle still lands
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    if (IMPL[i])
    begin : g_impl
      logic bit_q;
      always_ff @(posedge sys_clk)
      begin
        if (reset)
          bit_q <= 1'b0;
        else if (ce)
          bit_q <= f.set[i] | (bit_q & ~f.clr[i]);
      end
      // Every bit of q is a continuous driver, so none has two kinds
      assign q[i] = bit_q;
    end
    else
    begin : g_res
      // Reserved bit: no storage, reads zero
      assign q[i] = 1'b0;
    end
  end

  assign f.value = q;
endmodule

// [verilog/fsc_addr.sv]
// Fault address capture register, loaded by hardware, writable by software
`timescale 1ns/1ns
`include "fsc_consts.svh"
module fsc_addr (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  fsc_addr_if.owner a
);
  logic [31:0] q;

  // Hardware capture wins over a software write in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      q <= `FSC_RESET_ADDR;
    else if (ce)
    begin
      if (a.load)
        q <= a.load_val;
      else if (a.sw_we)
        q <= a.sw_data;
    end
  end

  assign a.value = q;
endmodule

// [verilog/fsc_top.sv]
// Fault status and fault address capture block of the system control space
`timescale 1ns/1ns
`include "fsc_consts.svh"

module fsc_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [1:0] reg_size,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_nonsecure,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire logic secure_only_fault_config,
  input wire logic stack_fault_evt,
  input wire logic unstack_fault_evt,
  input wire logic data_bus_err_evt,
  input wire logic [31:0] data_bus_err_addr,
  input wire logic ifetch_err_detect,
  input wire logic ifetch_issue,
  input wire logic ifetch_flush,
  input wire logic mem_fault_evt,
  input wire logic [31:0] mem_fault_addr,
  input wire logic divide_zero_evt,
  input wire logic unaligned_evt,
  input wire logic stack_overflow_evt,
  input wire logic coproc_absent_evt,
  input wire logic bad_pc_evt,
  input wire logic bad_state_evt,
  input wire logic undef_opcode_evt,
  input wire logic forced_evt,
  input wire logic vector_read_fail_evt,
  input wire logic debug_evt,
  output logic fault_flag_any
);
  fsc_flag_if #(.W(8)) mem_f ();
  fsc_flag_if #(.W(8)) bus_f ();
  fsc_flag_if #(.W(16)) use_f ();
  fsc_flag_if #(.W(32)) hard_f ();
  fsc_addr_if mem_a ();
  fsc_addr_if bus_a ();

  fsc_pkg::fsc_reg_t reg_hit;
  fsc_pkg::fsc_lanes_t lanes;
  logic legal;
  logic wr_go;
  logic hard_visible;
  logic ifetch_pending;
  logic [31:0] combined_word;
  logic [31:0] w1c_mask;
  logic [31:0] next_rdata;

  // Byte lanes touched by an access of the given size and address
  function automatic fsc_pkg::fsc_lanes_t lane_mask(
    input logic [1:0] size,
    input logic [1:0] low);
    fsc_pkg::fsc_lanes_t m;
    m = 4'h0;
    case (fsc_pkg::fsc_size_t'(size))
      fsc_pkg::FSC_SIZE_BYTE: m = 4'(4'h1 << low);
      fsc_pkg::FSC_SIZE_HALF: m = low[1] ? 4'hC : 4'h3;
      fsc_pkg::FSC_SIZE_WORD: m = 4'hF;
      default: m = 4'h0;
    endcase
    return m;
  endfunction

  // Spread a lane mask to a bit mask
  function automatic logic [31:0] lane_bits(input fsc_pkg::fsc_lanes_t m);
    logic [31:0] b;
    b = 32'h0;
    for (int i = 0; i < 4; i++)
      b[i*8 +: 8] = {8{m[i]}};
    return b;
  endfunction

  // Address decode on the word address
  always_comb
  begin
    case (reg_addr[31:2])
      30'(`FSC_ADDR_COMBINED >> 2): reg_hit = fsc_pkg::FSC_REG_COMBINED;
      30'(`FSC_ADDR_HARD >> 2): reg_hit = fsc_pkg::FSC_REG_HARD;
      30'(`FSC_ADDR_MEM_ADDR >> 2): reg_hit = fsc_pkg::FSC_REG_MEM_ADDR;
      30'(`FSC_ADDR_BUS_ADDR >> 2): reg_hit = fsc_pkg::FSC_REG_BUS_ADDR;
      default: reg_hit = fsc_pkg::FSC_REG_NONE;
    endcase
  end

  // Size legality: only the combined word takes narrow accesses
  always_comb
  begin
    lanes = lane_mask(reg_size, reg_addr[1:0]);
    legal = 1'b0;
    if (reg_hit == fsc_pkg::FSC_REG_COMBINED)
      legal = (reg_size == 2'h0) ||
              (reg_size == 2'h1 && !reg_addr[0]) ||
              (reg_size == 2'h2 && reg_addr[1:0] == 2'h0);
    else if (reg_hit != fsc_pkg::FSC_REG_NONE)
      legal = (reg_size == 2'h2) && (reg_addr[1:0] == 2'h0);
  end

  assign wr_go = reg_sel && reg_write && legal;
  // Ones written on the touched lanes only; a zero leaves a flag alone
  assign w1c_mask = reg_wdata & lane_bits(lanes);
  // Non-secure view of hard status is closed unless the config opens it
  assign hard_visible = secure_only_fault_config || !reg_nonsecure;

  // Fetch errors are held until the instruction is issued or discarded
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ifetch_pending <= 1'b0;
    else if (ce)
    begin
      if (ifetch_issue || ifetch_flush)
        ifetch_pending <= 1'b0;
      else if (ifetch_err_detect)
        ifetch_pending <= 1'b1;
    end
  end

  // Memory-manage byte: only its address valid flag is kept here
  always_comb
  begin
    mem_f.set = 8'h00;
    mem_f.clr = 8'h00;
    mem_f.set[`FSC_MEM_VALID_BIT] = mem_fault_evt;
    mem_f.clr[`FSC_MEM_VALID_BIT] = data_bus_err_evt;
    if (wr_go && reg_hit == fsc_pkg::FSC_REG_COMBINED)
      mem_f.clr = mem_f.clr | w1c_mask[`FSC_LANE_MEM*8 +: 8];
  end

  // Bus-fault byte events; stacking faults carry no address
  always_comb
  begin
    bus_f.set = 8'h00;
    bus_f.clr = 8'h00;
    bus_f.set[`FSC_BUS_VALID_BIT] = data_bus_err_evt;
    bus_f.clr[`FSC_BUS_VALID_BIT] = mem_fault_evt;
    bus_f.set[`FSC_BUS_STACK_BIT] = stack_fault_evt;
    bus_f.set[`FSC_BUS_UNSTACK_BIT] = unstack_fault_evt;
    bus_f.set[`FSC_BUS_PRECISE_BIT] = data_bus_err_evt;
    bus_f.set[`FSC_BUS_IFETCH_BIT] =
      ifetch_issue && (ifetch_pending || ifetch_err_detect);
    if (wr_go && reg_hit == fsc_pkg::FSC_REG_COMBINED)
      bus_f.clr = bus_f.clr | w1c_mask[`FSC_LANE_BUS*8 +: 8];
  end

  // Usage-fault halfword events
  always_comb
  begin
    use_f.set = 16'h0000;
    use_f.clr = 16'h0000;
    use_f.set[`FSC_USE_DIVZERO_BIT] = divide_zero_evt;
    use_f.set[`FSC_USE_UNALIGN_BIT] = unaligned_evt;
    use_f.set[`FSC_USE_STKOVF_BIT] = stack_overflow_evt;
    use_f.set[`FSC_USE_COPROCESSOR_ABSENT_FLAG_BIT] = coproc_absent_evt;
    use_f.set[`FSC_USE_BADPC_BIT] = bad_pc_evt;
    use_f.set[`FSC_USE_BADSTATE_BIT] = bad_state_evt;
    use_f.set[`FSC_USE_UNDEF_BIT] = undef_opcode_evt;
    if (wr_go && reg_hit == fsc_pkg::FSC_REG_COMBINED)
      use_f.clr = w1c_mask[`FSC_LANE_USAGE*8 +: 16];
  end

  // Hard-fault word events and software clear
  always_comb
  begin
    hard_f.set = 32'h0;
    hard_f.clr = 32'h0;
    hard_f.set[`FSC_HARD_DEBUG_BIT] = debug_evt;
    hard_f.set[`FSC_HARD_FORCED_BIT] = forced_evt;
    hard_f.set[`FSC_HARD_VECTOR_BIT] = vector_read_fail_evt;
    if (wr_go && reg_hit == fsc_pkg::FSC_REG_HARD && hard_visible)
      hard_f.clr = reg_wdata;
  end

  // Address capture: only faults that know their address load
  always_comb
  begin
    mem_a.load = mem_fault_evt;
    mem_a.load_val = mem_fault_addr;
    mem_a.sw_we = wr_go && reg_hit == fsc_pkg::FSC_REG_MEM_ADDR;
    mem_a.sw_data = reg_wdata;
    bus_a.load = data_bus_err_evt;
    bus_a.load_val = data_bus_err_addr;
    bus_a.sw_we = wr_go && reg_hit == fsc_pkg::FSC_REG_BUS_ADDR;
    bus_a.sw_data = reg_wdata;
  end

  fsc_sticky #(.W(8), .IMPL(`FSC_MEM_IMPL)) u_mem_status (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .f(mem_f)
  );

  fsc_sticky #(.W(8), .IMPL(`FSC_BUS_IMPL)) u_bus_status (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .f(bus_f)
  );

  fsc_sticky #(.W(16), .IMPL(`FSC_USE_IMPL)) u_usage_status (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .f(use_f)
  );

  fsc_sticky #(.W(32), .IMPL(`FSC_HARD_IMPL)) u_hard_status (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .f(hard_f)
  );

  fsc_addr u_mem_addr (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .a(mem_a)
  );

  fsc_addr u_bus_addr (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .a(bus_a)
  );

  // Combined word: usage halfword over bus byte over memory byte
  assign combined_word = {use_f.value, bus_f.value, mem_f.value};

  // Read mux; narrow reads return only their own lanes
  always_comb
  begin
    next_rdata = 32'h0;
    if (reg_sel && !reg_write && legal)
    begin
      case (reg_hit)
        fsc_pkg::FSC_REG_COMBINED:
          next_rdata = combined_word & lane_bits(lanes);
        fsc_pkg::FSC_REG_HARD:
          next_rdata = hard_visible ? hard_f.value : 32'h0;
        fsc_pkg::FSC_REG_MEM_ADDR: next_rdata = mem_a.value;
        fsc_pkg::FSC_REG_BUS_ADDR: next_rdata = bus_a.value;
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // Registered answer one cycle after every select, mapped or not
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      reg_rdata <= `FSC_RESET_STATUS;
      reg_ack <= 1'b0;
    end
    else if (ce)
    begin
      reg_rdata <= next_rdata;
      reg_ack <= reg_sel;
    end
  end

  // Summary level so the exception logic can see any recorded cause
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      fault_flag_any <= 1'b0;
    else if (ce)
      fault_flag_any <= (|bus_f.value[6:0]) || (|use_f.value) ||
                        (|hard_f.value);
  end
endmodule

// [tb/fsc_checker_assertions.sv]
// Port assertions for the fault status block
`timescale 1ns/1ns
`include "fsc_consts.svh"
module fsc_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic reg_nonsecure,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic secure_only_fault_config,
  input wire logic data_bus_err_evt,
  input wire logic stack_fault_evt,
  input wire logic divide_zero_evt,
  input wire logic forced_evt,
  input wire logic vector_read_fail_evt,
  input wire logic fault_flag_any
);
  // A frozen clock enable stretches every latency, so it aborts attempts
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset || !ce);

  chk_ack_follows: assert property (reg_sel |=> reg_ack)
    else $error("no answer after a request");
  chk_ack_only: assert property (!reg_sel |=> !reg_ack)
    else $error("answer without a request");
  chk_write_zero: assert property (reg_sel && reg_write
    |=> reg_rdata == 32'h0)
    else $error("write returned data");
  chk_unmapped_zero: assert property (reg_sel &&
    !(reg_addr inside {[32'hE000ED28:32'hE000ED37]}) |=> reg_rdata == 0)
    else $error("unmapped read returned data");
  chk_hard_raz: assert property (reg_sel && reg_nonsecure &&
    reg_addr == `FSC_ADDR_HARD && !secure_only_fault_config
    |=> reg_rdata == 0)
    else $error("hard status seen from non-secure state");
  chk_hard_reserved: assert property (reg_sel &&
    reg_addr == `FSC_ADDR_HARD |=> (reg_rdata & ~`FSC_HARD_IMPL) == 0)
    else $error("reserved hard status bits set");
  chk_bus_err_any: assert property (data_bus_err_evt
    |-> ##2 fault_flag_any)
    else $error("bus error left no flag");
  chk_stack_any: assert property (stack_fault_evt |-> ##2 fault_flag_any)
    else $error("stacking fault left no flag");
  chk_divzero_any: assert property (divide_zero_evt
    |-> ##2 fault_flag_any)
    else $error("divide fault left no flag");
  chk_hard_any: assert property (forced_evt || vector_read_fail_evt
    |-> ##2 fault_flag_any)
    else $error("hard fault left no flag");
  chk_flag_sticky: assert property ($fell(fault_flag_any) |->
    $past(reg_sel && reg_write, 2) || $past(reset) || $past(reset, 2))
    else $error("flag dropped without a write");
endmodule

bind fsc_top fsc_checker u_chk (.sys_clk, .reset, .ce, .reg_sel, .reg_write,
  .reg_addr, .reg_nonsecure, .reg_rdata, .reg_ack, .secure_only_fault_config,
  .data_bus_err_evt, .stack_fault_evt, .divide_zero_evt, .forced_evt,
  .vector_read_fail_evt, .fault_flag_any);

// [tb/fsc_fault_src.sv]
// Model of the fault detection logic that pulses the event inputs
`timescale 1ns/1ns
module fsc_fault_src (
  input wire logic sys_clk,
  output logic [16:0] ev,
  output logic [31:0] err_addr
);
  logic [16:0] req = '0;
  logic [31:0] req_addr = '0;
  initial ev = '0;
  initial err_addr = '0;
  // Idle address flips every cycle so a late capture cannot pass
  always @(posedge sys_clk)
  begin
    ev <= req;
    err_addr <= (req != 0) ? req_addr : ~err_addr;
  end
  // One-cycle pulse; fetch detect and issue come as separate calls
  task automatic fire(input logic [16:0] m, input logic [31:0] a);
    @(negedge sys_clk);
    req = m;
    req_addr = a;
    @(negedge sys_clk);
    req = '0;
  endtask
endmodule

// [tb/fault_status_capture_bench.sv]
// Self-checking bench for the fault status block
`timescale 1ns/1ns
`include "fsc_consts.svh"
module fault_status_capture_bench;
  localparam logic [31:0] ca = `FSC_ADDR_COMBINED;
  localparam logic [31:0] ha = `FSC_ADDR_HARD;
  localparam logic [31:0] ma = `FSC_ADDR_MEM_ADDR;
  localparam logic [31:0] ba = `FSC_ADDR_BUS_ADDR;
  logic sys_clk = 0, reset = 1, ce = 1, reg_sel = 0, reg_write = 0;
  logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, a, m, ra;
  logic [1:0] reg_size = '0;
  logic reg_nonsecure = 0, ns = 0, sofc = 1, reg_ack, fault_flag_any;
  logic [16:0] ev;
  logic [31:0] err_addr;
  int bad_count = 0, n_tests = 0, k;
  int ks[14] = '{0, 1, 2, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16};

  always #20 sys_clk = ~sys_clk;

  fsc_fault_src src (.sys_clk, .ev, .err_addr);
  fsc_top dut (.sys_clk, .reset, .ce, .reg_sel, .reg_write, .reg_addr,
    .reg_size, .reg_wdata, .reg_nonsecure, .reg_rdata, .reg_ack,
    .secure_only_fault_config(sofc), .stack_fault_evt(ev[0]),
    .unstack_fault_evt(ev[1]), .data_bus_err_evt(ev[2]),
    .data_bus_err_addr(err_addr), .ifetch_err_detect(ev[3]),
    .ifetch_issue(ev[4]), .ifetch_flush(ev[5]), .mem_fault_evt(ev[6]),
    .mem_fault_addr(err_addr), .divide_zero_evt(ev[7]),
    .unaligned_evt(ev[8]), .stack_overflow_evt(ev[9]),
    .coproc_absent_evt(ev[10]), .bad_pc_evt(ev[11]),
    .bad_state_evt(ev[12]), .undef_opcode_evt(ev[13]),
    .forced_evt(ev[14]), .vector_read_fail_evt(ev[15]),
    .debug_evt(ev[16]), .fault_flag_any);

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One request, answered exactly one cycle later; lines scrambled after
  task automatic acc(input logic w, input logic [31:0] ad,
    input logic [1:0] s, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    reg_sel <= 1'b1;
    reg_write <= w;
    reg_addr <= ad;
    reg_size <= s;
    reg_wdata <= d;
    reg_nonsecure <= ns;
    @(posedge sys_clk);
    reg_sel <= 1'b0;
    reg_addr <= ~ad;
    reg_wdata <= ~d;
    #1;
    cmp("ack", 32'h1, {31'h0, reg_ack});
    q = reg_rdata;
  endtask

  task automatic rd(input logic [31:0] ad, input logic [1:0] s,
    input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, ad, s, 32'h0, q);
    cmp("rdata", e, q);
  endtask

  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, ad, 2'h2, d, q);
  endtask

  // Flag position in the register that each event reaches
  function automatic logic [31:0] exp_mask(input int e);
    int ub[7] = '{25, 24, 20, 19, 18, 17, 16};
    case (e)
      0: return 32'h00002000;
      1: return 32'h00001000;
      2: return 32'h00008200;
      6: return 32'h00000080;
      14: return 32'h40000000;
      15: return 32'h00000002;
      16: return 32'h80000000;
      default: return 32'h1 << ub[e - 7];
    endcase
  endfunction

  // Guard against a hang in any scenario
  initial
  begin
    #800000;
    bad_count++;
    final_report;
  end

  initial
  begin
    void'($urandom(32'h19B8));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ca, 2'h2, 32'h0);
    rd(ba, 2'h2, 32'h0);
    foreach (ks[i])
    begin
      k = ks[i];
      a = $urandom;
      ns = 1'($urandom);
      m = exp_mask(k);
      ra = (k > 13) ? ha : ca;
      src.fire(17'h1 << k, a);
      rd(ra, 2'h2, m);
      // Summary level ignores the two address valid flags
      cmp("flag_any", {31'h0, k != 6}, {31'h0, fault_flag_any});
      if (k != 16)
        wr(ra, ~m);
      rd(ra, 2'h2, m);
      wr(ra, (k > 13) ? 32'hFFFFFFFF : m);
      rd(ra, 2'h2, 32'h0);
      cmp("flag_any", 32'h0, {31'h0, fault_flag_any});
      if (k == 2)
        rd(ba, 2'h2, a);
      if (k == 6)
        rd(ma, 2'h2, a);
    end
    a = $urandom;
    src.fire(17'h4, a);
    src.fire(17'h3, ~a);
    rd(ba, 2'h2, a);
    src.fire(17'h40, a + 1);
    rd(ca, 2'h2, 32'h00003280);
    rd(ma, 2'h2, a + 1);
    wr(ca, 32'h00003280);
    src.fire(17'h8, a);
    repeat (4) @(posedge sys_clk);
    rd(ca, 2'h2, 32'h0);
    src.fire(17'h20, a);
    src.fire(17'h10, a);
    rd(ca, 2'h2, 32'h0);
    src.fire(17'h8, a);
    src.fire(17'h10, a);
    rd(ca, 2'h2, 32'h00000100);
    rd(ba, 2'h2, a);
    wr(ca, 32'h00000100);
    src.fire(17'h4084, ~a);
    // Handler order: address first, then its valid flag in the next read
    rd(ba, 2'h2, ~a);
    rd(ca + 1, 2'h0, 32'h00008200);
    rd(ca + 2, 2'h1, 32'h02000000);
    rd(ca, 2'h1, 32'h00008200);
    rd(32'hE000ED38, 2'h2, 32'h0);
    rd(ha + 3, 2'h0, 32'h0);
    @(posedge sys_clk);
    sofc <= 1'b0;
    ns = 1'b1;
    rd(ha, 2'h2, 32'h0);
    wr(ha, 32'hFFFFFFFF);
    ns = 1'b0;
    rd(ha, 2'h2, 32'h40000000);
    wr(ha, 32'hFFFFFFFF);
    wr(ca, 32'hFFFFFFFF);
    rd(ca, 2'h2, 32'h0);
    a = $urandom;
    wr(ma, a);
    rd(ma, 2'h2, a);
    // An event that lands while the enable is low must leave no flag
    @(posedge sys_clk);
    ce <= 1'b0;
    src.fire(17'h100, a);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(ca, 2'h2, 32'h0);
    src.fire(17'h80, a);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ca, 2'h2, 32'h0);
    rd(ma, 2'h2, 32'h0);
    final_report;
  end
endmodule
